// ===== rtl/op_status_pkg.sv
// Constants for the operation status group and standard event enable.
// Assumes a host command decoder that presents register selects and strobes.
//
// Functional notes
// RULE1 - Event enable mask drives summary bit 5
// RULE2 - Enable mask written and read back whole
// RULE3 - Operation group produces summary bit 7
// RULE4 - Condition register is live, writes ignored
// RULE5 - Bit 0 shows calibration in process
// RULE6 - Bit 1 settling, bit 3 sweeping
// RULE7 - Bit 4 shows error rate measuring
// RULE8 - Bit 5 shows waiting for trigger
// RULE9 - Bit 9 shows modulation zero calibration
// RULE10 - Bit 10 is baseband busy summary
// RULE11 - Bit 11 shows pre-sweep calculation
// RULE12 - Bit 12 high through tester synchronization
// RULE13 - Unused condition bits always read zero
// RULE14 - Unsupported variant bits read zero
// RULE15 - Condition query returns weighted sum
// RULE16 - Transition masks select edges setting events
// RULE17 - Event register latches qualifying transitions
// RULE18 - Event read returns content then clears
// RULE19 - Suppress control stops group maintenance; here it only blocks new events, condition still tracks
// RULE20 - Summary is OR of event AND enable
// RULE21 - Events clear by read or clear-status
// RULE22 - New event survives simultaneous read clear
// RULE23 - Reset values defined for all registers
package op_status_pkg;

   // --------------------------------------------------------------
   // Register selects
   // --------------------------------------------------------------
   localparam logic [2:0] SEL_STD_ENABLE = 3'h0;
   localparam logic [2:0] SEL_COND       = 3'h1;
   localparam logic [2:0] SEL_FALL       = 3'h2;
   localparam logic [2:0] SEL_RISE       = 3'h3;
   localparam logic [2:0] SEL_EVENT      = 3'h4;
   localparam logic [2:0] SEL_OP_ENABLE  = 3'h5;

   // --------------------------------------------------------------
   // Condition bit positions
   // --------------------------------------------------------------
   localparam int BIT_IQ_CAL     = 0;
   localparam int BIT_SETTLING   = 1;
   localparam int BIT_SWEEPING   = 3;
   localparam int BIT_MEASURING  = 4;
   localparam int BIT_WAIT_TRIG  = 5;
   localparam int BIT_DC_NULL    = 9;
   localparam int BIT_BB_BUSY    = 10;
   localparam int BIT_SWEEP_CALC = 11;
   localparam int BIT_TEST_SYNC  = 12;

   // Bits that may ever be 1 (0,1,3,4,5,9,10,11,12)
   localparam logic [15:0] COND_USED_MASK = 16'h1E3B;

   // --------------------------------------------------------------
   // Reset values
   // --------------------------------------------------------------
   localparam logic [7:0]  STD_ENABLE_RESET = 8'h00;
   localparam logic [15:0] FALL_RESET       = 16'h0000;
   localparam logic [15:0] RISE_RESET       = 16'hFFFF;
   localparam logic [15:0] EVENT_RESET      = 16'h0000;
   localparam logic [15:0] OP_ENABLE_RESET  = 16'h0000;

   // Switching time saved by suppression, in ns
   localparam int SUPPRESS_SAVING_NS = 50000;

endpackage : op_status_pkg

// ===== rtl/operation_status_group.sv
// Operation status group with standard event enable mask.
// Assumes a command decoder issuing one-cycle write/read strobes with a select.
// Status sources are level signals already timed to clk_sys.
`timescale 1ns/1ps
module operation_status_group #(
   parameter logic [15:0] SUPPORTED_MASK = 16'hFFFF
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // Host register access
   input  wire logic [2:0]  reg_sel,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        clear_status,
   output logic      [15:0] reg_rdata,
   output logic             reg_rvalid,
   // Control
   input  wire logic        operation_status_suppress,
   // Live status sources
   input  wire logic        iq_cal_active,
   input  wire logic        settling,
   input  wire logic        sweeping,
   input  wire logic        bit_error_tester_measuring,
   input  wire logic        waiting_for_trigger,
   input  wire logic        dc_coupled_fm_null,
   input  wire logic        baseband_busy,
   input  wire logic        sweep_calculating,
   input  wire logic        bit_error_tester_sync,
   // Standard event status bits
   input  wire logic [7:0]  std_event_status,
   // Summary outputs
   output logic             std_event_summary,
   output logic             operation_summary
);

   logic [7:0]  std_enable;
   logic [15:0] condition;
   logic [15:0] cond_prev;
   logic [15:0] fall_filter;
   logic [15:0] rise_filter;
   logic [15:0] event_latch;
   logic [15:0] op_enable;
   logic [15:0] raw_cond;
   logic [15:0] next_set;
   logic        event_read;

   // --------------------------------------------------------------
   // Parameter check
   // --------------------------------------------------------------
   // A mask that keeps no used bit would leave the summary dead
   if ((SUPPORTED_MASK & op_status_pkg::COND_USED_MASK) == 16'h0000) begin : g_mask_check
      $error("SUPPORTED_MASK keeps no condition bit");
   end

   // --------------------------------------------------------------
   // Select decoding
   // --------------------------------------------------------------
   // High when a strobe addresses the given register
   function automatic logic hits(input logic       strobe,
                                 input logic [2:0] sel,
                                 input logic [2:0] code);
      hits = strobe && (sel == code);
   endfunction : hits

   // --------------------------------------------------------------
   // Live condition assembly
   // --------------------------------------------------------------
   // RULE5 RULE6 RULE7 map sources
   always_comb begin
      raw_cond = 16'h0000;
      raw_cond[op_status_pkg::BIT_IQ_CAL]     = iq_cal_active;
      raw_cond[op_status_pkg::BIT_SETTLING]   = settling;
      raw_cond[op_status_pkg::BIT_SWEEPING]   = sweeping;
      raw_cond[op_status_pkg::BIT_MEASURING]  = bit_error_tester_measuring;
      // RULE8 RULE9 RULE10 more sources
      raw_cond[op_status_pkg::BIT_WAIT_TRIG]  = waiting_for_trigger;
      raw_cond[op_status_pkg::BIT_DC_NULL]    = dc_coupled_fm_null;
      raw_cond[op_status_pkg::BIT_BB_BUSY]    = baseband_busy;
      // RULE11 RULE12 remaining sources
      raw_cond[op_status_pkg::BIT_SWEEP_CALC] = sweep_calculating;
      raw_cond[op_status_pkg::BIT_TEST_SYNC]  = bit_error_tester_sync;
   end

   // Condition register tracks sources every cycle
   // Unused and unsupported bits are forced low here, not at read time
   // RULE4 RULE13 RULE14 live and masked
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         condition <= 16'h0000;
         cond_prev <= 16'h0000;
      end else begin
         condition <= raw_cond & op_status_pkg::COND_USED_MASK & SUPPORTED_MASK;
         cond_prev <= condition;
      end
   end

   // --------------------------------------------------------------
   // Transition detect
   // --------------------------------------------------------------
   // Both samples are registered, so each edge is seen in one cycle only
   // RULE16 filtered edges
   assign next_set = (rise_filter & condition & ~cond_prev)
                   | (fall_filter & ~condition & cond_prev);
   // Destructive read strobe
   assign event_read = hits(reg_read, reg_sel, op_status_pkg::SEL_EVENT);

   // --------------------------------------------------------------
   // Writable masks
   // --------------------------------------------------------------
   // RULE2 RULE23 mask writes
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         std_enable  <= op_status_pkg::STD_ENABLE_RESET;
         fall_filter <= op_status_pkg::FALL_RESET;
         rise_filter <= op_status_pkg::RISE_RESET;
         op_enable   <= op_status_pkg::OP_ENABLE_RESET;
      end else if (reg_write) begin
         unique case (reg_sel)
            op_status_pkg::SEL_STD_ENABLE: std_enable  <= reg_wdata[7:0];
            op_status_pkg::SEL_FALL:       fall_filter <= reg_wdata;
            op_status_pkg::SEL_RISE:       rise_filter <= reg_wdata;
            op_status_pkg::SEL_OP_ENABLE:  op_enable   <= reg_wdata;
            default: ;  // Condition and event ignore writes
         endcase
      end
   end

   // --------------------------------------------------------------
   // Event latch
   // --------------------------------------------------------------
   // A read or clear-status drops old bits but keeps this cycle's edges,
   // so a transition on the clearing cycle is kept unless operation_status_suppress is high
   // RULE17 RULE18 RULE21 RULE22 latch, clear, set wins
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         event_latch <= op_status_pkg::EVENT_RESET;
      end else if (operation_status_suppress) begin
         // RULE19 suppress maintenance
         event_latch <= event_latch & ~{16{event_read | clear_status}};
      end else if (event_read || clear_status) begin
         event_latch <= next_set;
      end else begin
         event_latch <= event_latch | next_set;
      end
   end

   // --------------------------------------------------------------
   // Read port
   // --------------------------------------------------------------
   // Data holds until the next read; valid marks the answer cycle
   // RULE15 read returns weighted bits
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         reg_rdata  <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_read;
         if (reg_read) begin
            unique case (reg_sel)
               op_status_pkg::SEL_STD_ENABLE: reg_rdata <= {8'h00, std_enable};
               op_status_pkg::SEL_COND:       reg_rdata <= condition;
               op_status_pkg::SEL_FALL:       reg_rdata <= fall_filter;
               op_status_pkg::SEL_RISE:       reg_rdata <= rise_filter;
               op_status_pkg::SEL_EVENT:      reg_rdata <= event_latch;
               op_status_pkg::SEL_OP_ENABLE:  reg_rdata <= op_enable;
               default:                       reg_rdata <= 16'h0000;
            endcase
         end
      end
   end

   // --------------------------------------------------------------
   // Summary bits
   // --------------------------------------------------------------
   // Standard summary lags its sources by one clock, operation summary by three
   // RULE1 RULE3 RULE20 AND-OR summaries
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         std_event_summary <= 1'b0;
         operation_summary <= 1'b0;
      end else begin
         std_event_summary <= |(std_event_status & std_enable);
         operation_summary <= |(event_latch & op_enable);
      end
   end

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   unused_zero_a: assert property (  // RULE13
      @(posedge clk_sys) disable iff (reset)
      (condition & ~op_status_pkg::COND_USED_MASK) == 16'h0000)
      else $error("unused condition bit set");

   cond_track_a: assert property (  // RULE4
      @(posedge clk_sys) disable iff (reset)
      ##1 condition == ($past(raw_cond) & op_status_pkg::COND_USED_MASK & SUPPORTED_MASK))
      else $error("condition not tracking");

   rise_latch_a: assert property (  // RULE16
      @(posedge clk_sys) disable iff (reset)
      (!operation_status_suppress && |next_set) |=> ((event_latch & $past(next_set))
         == $past(next_set)))
      else $error("transition not latched");

   hold_a: assert property (  // RULE17
      @(posedge clk_sys) disable iff (reset)
      (!event_read && !clear_status) |=> ((event_latch & $past(event_latch))
         == $past(event_latch)))
      else $error("event bit lost");

   read_clear_a: assert property (  // RULE18
      @(posedge clk_sys) disable iff (reset)
      (event_read && next_set == 16'h0000) |=> event_latch == 16'h0000)
      else $error("event not cleared by read");

   read_data_a: assert property (  // RULE18
      @(posedge clk_sys) disable iff (reset)
      event_read |=> (reg_rvalid && reg_rdata == $past(event_latch)))
      else $error("event read value wrong");

   set_wins_a: assert property (  // RULE22
      @(posedge clk_sys) disable iff (reset)
      (event_read && !operation_status_suppress) |=> event_latch == $past(next_set))
      else $error("simultaneous event lost");

   op_summary_a: assert property (  // RULE20
      @(posedge clk_sys) disable iff (reset)
      ##1 operation_summary == |($past(event_latch) & $past(op_enable)))
      else $error("operation summary wrong");

   std_summary_a: assert property (  // RULE1
      @(posedge clk_sys) disable iff (reset)
      ##1 std_event_summary == |($past(std_event_status) & $past(std_enable)))
      else $error("standard summary wrong");

   mask_rw_a: assert property (  // RULE2
      @(posedge clk_sys) disable iff (reset)
      (reg_write && reg_sel == op_status_pkg::SEL_STD_ENABLE) |=> std_enable
         == $past(reg_wdata[7:0]))
      else $error("enable mask not stored");

   // Mask writes land whole in the selected register
   fall_store_a: assert property (  // RULE16
      @(posedge clk_sys) disable iff (reset)
      hits(reg_write, reg_sel, op_status_pkg::SEL_FALL)
         |=> fall_filter == $past(reg_wdata))
      else $error("falling filter not stored");

   rise_store_a: assert property (  // RULE16
      @(posedge clk_sys) disable iff (reset)
      hits(reg_write, reg_sel, op_status_pkg::SEL_RISE)
         |=> rise_filter == $past(reg_wdata))
      else $error("rising filter not stored");

   op_en_store_a: assert property (  // RULE20
      @(posedge clk_sys) disable iff (reset)
      hits(reg_write, reg_sel, op_status_pkg::SEL_OP_ENABLE)
         |=> op_enable == $past(reg_wdata))
      else $error("operation enable not stored");

   // Queries return the register sampled at the read edge
   std_read_a: assert property (  // RULE2
      @(posedge clk_sys) disable iff (reset)
      hits(reg_read, reg_sel, op_status_pkg::SEL_STD_ENABLE)
         |=> reg_rdata == {8'h00, $past(std_enable)})
      else $error("enable mask read wrong");

   cond_read_a: assert property (  // RULE15
      @(posedge clk_sys) disable iff (reset)
      hits(reg_read, reg_sel, op_status_pkg::SEL_COND)
         |=> reg_rdata == $past(condition))
      else $error("condition read wrong");

   fall_read_a: assert property (  // RULE16
      @(posedge clk_sys) disable iff (reset)
      hits(reg_read, reg_sel, op_status_pkg::SEL_FALL)
         |=> reg_rdata == $past(fall_filter))
      else $error("falling filter read wrong");

   rise_read_a: assert property (  // RULE16
      @(posedge clk_sys) disable iff (reset)
      hits(reg_read, reg_sel, op_status_pkg::SEL_RISE)
         |=> reg_rdata == $past(rise_filter))
      else $error("rising filter read wrong");

   op_en_read_a: assert property (  // RULE20
      @(posedge clk_sys) disable iff (reset)
      hits(reg_read, reg_sel, op_status_pkg::SEL_OP_ENABLE)
         |=> reg_rdata == $past(op_enable))
      else $error("operation enable read wrong");

   // Answer timing of the read port
   rvalid_pulse_a: assert property (  // RULE15
      @(posedge clk_sys) disable iff (reset)
      ##1 reg_rvalid == $past(reg_read))
      else $error("read valid misplaced");

   rdata_hold_a: assert property (  // RULE15
      @(posedge clk_sys) disable iff (reset)
      !reg_read |=> $stable(reg_rdata))
      else $error("read data changed without read");

   // Condition bits outside the variant stay low
   unsupported_zero_a: assert property (  // RULE14
      @(posedge clk_sys) disable iff (reset)
      (condition & ~SUPPORTED_MASK) == 16'h0000)
      else $error("unsupported condition bit set");

   prev_track_a: assert property (  // RULE16
      @(posedge clk_sys) disable iff (reset)
      ##1 cond_prev == $past(condition))
      else $error("edge reference not delayed");

   // Event latch and summary bookkeeping
   suppress_hold_a: assert property (  // RULE19
      @(posedge clk_sys) disable iff (reset)
      (operation_status_suppress && !event_read && !clear_status)
         |=> event_latch == $past(event_latch))
      else $error("event changed while suppressed");

   clear_status_a: assert property (  // RULE21
      @(posedge clk_sys) disable iff (reset)
      clear_status |=> (event_latch & ~$past(next_set)) == 16'h0000)
      else $error("clear-status left old events");

   no_spurious_a: assert property (  // RULE17
      @(posedge clk_sys) disable iff (reset)
      ##1 (event_latch & ~$past(event_latch) & ~$past(next_set)) == 16'h0000)
      else $error("event set without transition");

   filter_gate_a: assert property (  // RULE16
      @(posedge clk_sys) disable iff (reset)
      ##1 (event_latch & ~$past(event_latch)
         & ~($past(rise_filter) | $past(fall_filter))) == 16'h0000)
      else $error("event set by masked edge");

   op_disabled_a: assert property (  // RULE3
      @(posedge clk_sys) disable iff (reset)
      (op_enable == 16'h0000) |=> !operation_summary)
      else $error("summary without enable");

   summary_low_a: assert property (  // RULE1
      @(posedge clk_sys) disable iff (reset)
      (std_enable == 8'h00) |=> !std_event_summary)
      else $error("standard summary without enable");

endmodule : operation_status_group

// ===== verification/host_model.sv
// Host model: issues register writes and reads to the status block.
// Assumes strobes are sampled on rising clk_sys, driven here on falling.
`timescale 1ns/1ps
module host_model (
   // Clock
   input  wire logic        clk_sys,
   // Register access
   output logic      [2:0]  reg_sel,
   output logic             reg_write,
   output logic             reg_read,
   output logic      [15:0] reg_wdata,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rvalid
);
   // Idle bus at time zero
   initial begin
      reg_sel = 3'h0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_wdata = 16'h0000;
   end
   task automatic wr(input logic [2:0] sel, input logic [15:0] data);
      @(negedge clk_sys);
      reg_sel = sel;
      reg_wdata = data;
      reg_write = 1'b1;
      @(negedge clk_sys);
      reg_write = 1'b0;
      reg_wdata = ~data; // Released data never shows the old word
   endtask : wr
   // One read, answer taken while valid stands
   task automatic rd(input logic [2:0] sel, output logic [15:0] data, output logic ok);
      @(negedge clk_sys);
      reg_sel = sel;
      reg_read = 1'b1;
      @(negedge clk_sys);
      reg_read = 1'b0;
      data = reg_rdata;
      ok = reg_rvalid;
   endtask : rd
endmodule : host_model

// ===== verification/tb.sv
// Self-checking bench for the operation status group.
// Assumes reads answer one cycle after the strobe, as the host model expects.
`timescale 1ns/1ps
module tb;
   logic        clk_sys;
   logic        reset;
   logic [2:0]  reg_sel;
   logic        reg_write;
   logic        reg_read;
   logic [15:0] reg_wdata;
   logic        clear_status;
   logic [15:0] reg_rdata;
   logic        reg_rvalid;
   logic        suppress;
   logic [8:0]  src;
   logic [7:0]  std_event_status;
   logic        std_event_summary;
   logic        operation_summary;
   logic [15:0] rv;
   logic        ok;
   int          miscompares = 0;
   int          compares = 0;
   int          cycles = 0;
   int          pos [9] = '{0, 1, 3, 4, 5, 9, 10, 11, 12}; // Condition bit of each source

   operation_status_group dut (.clk_sys(clk_sys), .reset(reset), .reg_sel(reg_sel),
      .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
      .clear_status(clear_status), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .operation_status_suppress(suppress), .iq_cal_active(src[0]), .settling(src[1]),
      .sweeping(src[2]), .bit_error_tester_measuring(src[3]), .waiting_for_trigger(src[4]),
      .dc_coupled_fm_null(src[5]), .baseband_busy(src[6]), .sweep_calculating(src[7]),
      .bit_error_tester_sync(src[8]), .std_event_status(std_event_status),
      .std_event_summary(std_event_summary), .operation_summary(operation_summary));
   host_model host (.clk_sys(clk_sys), .reg_sel(reg_sel), .reg_write(reg_write),
      .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic rdc(input logic [2:0] sel, input logic [15:0] exp, input string name);
      host.rd(sel, rv, ok);
      check("read valid", {15'h0000, ok}, 16'h0001);
      check(name, rv, exp);
   endtask : rdc
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : wait_n
   task automatic complete_run();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run

   // Reset values of every select
   task automatic test_reset();
      for (int i = 0; i < 6; i++) begin
         rdc(3'(i), (3'(i) == op_status_pkg::SEL_RISE) ? 16'hFFFF : 16'h0000, "reset");
      end
      $display("test reset done");
   endtask : test_reset
   // Standard enable mask and its summary
   task automatic test_std();
      host.wr(op_status_pkg::SEL_STD_ENABLE, 16'h00C0);
      rdc(op_status_pkg::SEL_STD_ENABLE, 16'h00C0, "std enable");
      std_event_status = 8'h40;
      wait_n(3);
      check("std summary", {15'h0000, std_event_summary}, 16'h0001);
      std_event_status = 8'h3F;
      wait_n(3);
      check("std summary", {15'h0000, std_event_summary}, 16'h0000);
      $display("test std done");
   endtask : test_std
   // Live condition bits, one source at a time, then combined sources and an ignored write
   task automatic test_cond();
      for (int i = 0; i < 9; i++) begin
         src = 9'h001 << i;
         wait_n(2);
         rdc(op_status_pkg::SEL_COND, 16'h0001 << pos[i], "condition");
      end
      src = 9'h024;
      wait_n(2);
      rdc(op_status_pkg::SEL_COND, 16'h0208, "sum 520");
      host.wr(op_status_pkg::SEL_COND, 16'hFFFF);
      rdc(op_status_pkg::SEL_COND, 16'h0208, "cond write");
      src = 9'h1FF;
      wait_n(2);
      rdc(op_status_pkg::SEL_COND, 16'h1E3B, "unused bits");
      src = 9'h000;
      wait_n(5);
      rdc(op_status_pkg::SEL_EVENT, 16'h1E3B, "risen events");
      $display("test cond done");
   endtask : test_cond
   // Filters, latching, destructive read, clear and suppress
   task automatic test_event();
      host.wr(op_status_pkg::SEL_OP_ENABLE, 16'h0008);
      src = 9'h004;
      wait_n(5);
      check("op summary", {15'h0000, operation_summary}, 16'h0001);
      rdc(op_status_pkg::SEL_EVENT, 16'h0008, "event");
      rdc(op_status_pkg::SEL_EVENT, 16'h0000, "event reread");
      host.wr(op_status_pkg::SEL_RISE, 16'h0000);
      host.wr(op_status_pkg::SEL_FALL, 16'h0008);
      rdc(op_status_pkg::SEL_FALL, 16'h0008, "falling");
      src = 9'h000;
      wait_n(5);
      rdc(op_status_pkg::SEL_EVENT, 16'h0008, "fall event");
      src = 9'h004;
      wait_n(5);
      rdc(op_status_pkg::SEL_EVENT, 16'h0000, "masked rise");
      src = 9'h000;
      wait_n(5);
      check("op summary", {15'h0000, operation_summary}, 16'h0001);
      clear_status = 1'b1;
      wait_n(1);
      clear_status = 1'b0;
      wait_n(3);
      check("op summary", {15'h0000, operation_summary}, 16'h0000);
      rdc(op_status_pkg::SEL_EVENT, 16'h0000, "cleared");
      suppress = 1'b1;
      src = 9'h004;
      wait_n(3);
      src = 9'h000;
      wait_n(5);
      rdc(op_status_pkg::SEL_EVENT, 16'h0000, "suppressed");
      suppress = 1'b0;
      $display("test event done");
   endtask : test_event
   // Transition landing on a destructive read
   task automatic test_race();
      host.wr(op_status_pkg::SEL_RISE, 16'h0008);
      src = 9'h004;
      host.rd(op_status_pkg::SEL_EVENT, rv, ok);
      check("race old event", rv, 16'h0000);
      check("race valid", {15'h0000, ok}, 16'h0001);
      rdc(op_status_pkg::SEL_EVENT, 16'h0008, "race kept event");
      $display("test race done");
   endtask : test_race
   // Reset in mid-run after a summary has been raised
   task automatic test_rereset();
      src = 9'h000;
      wait_n(4);
      check("op summary", {15'h0000, operation_summary}, 16'h0001);
      reset = 1'b1;
      wait_n(2);
      check("op summary", {15'h0000, operation_summary}, 16'h0000);
      check("read valid", {15'h0000, reg_rvalid}, 16'h0000);
      reset = 1'b0;
      test_reset();
      $display("test rereset done");
   endtask : test_rereset

   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         complete_run();
      end
   end
   // Main sequence
   initial begin
      reset = 1'b1;
      clear_status = 1'b0;
      suppress = 1'b0;
      src = 9'h000;
      std_event_status = 8'h00;
      repeat (10) @(negedge clk_sys);
      reset = 1'b0;
      test_reset();
      test_std();
      test_cond();
      test_event();
      test_race();
      test_rereset();
      complete_run();
   end
endmodule : tb
